// file: ofrf_core_model.sv
// core-side request source model feeding the offcore response filter
`timescale 1ns/1ps
module ofrf_core_model
(
	// clock
	input wire logic clk,
	// issue side
	output logic req_issue,
	output logic [15:0] req_type,
	output logic [13:0] rsp_supplier,
	output logic [6:0] rsp_snoop,
	// retire side
	output logic req_retire,
	output logic [15:0] retire_type
);
	// ------------------------------------------------------------
	// idle state at time zero
	// ------------------------------------------------------------
	initial
	begin
		req_issue = 1'b0;
		req_type = 16'h0000;
		rsp_supplier = 14'h0000;
		rsp_snoop = 7'h00;
		req_retire = 1'b0;
		retire_type = 16'h0000;
	end

	// one request for one cycle; idle fields flip so stale data never
	// looks like a live request
	task automatic issue(input logic [15:0] t, input logic [13:0] s,
		input logic [6:0] n);
		@(posedge clk);
		req_issue <= 1'b1;
		req_type <= t;
		rsp_supplier <= s;
		rsp_snoop <= n;
		@(posedge clk);
		req_issue <= 1'b0;
		req_type <= ~t;
		rsp_supplier <= ~s;
		rsp_snoop <= ~n;
	endtask

	// completion of one outstanding request
	task automatic retire(input logic [15:0] t);
		@(posedge clk);
		req_retire <= 1'b1;
		retire_type <= t;
		@(posedge clk);
		req_retire <= 1'b0;
		retire_type <= ~t;
	endtask
endmodule

// file: ofrf_match.sv
// one filter: validity and per-request match against a filter register
`timescale 1ns/1ps
module ofrf_match
	import ofrf_pkg::*;
(
	// filter contents
	input wire logic [63:0] filter,
	// request classification
	input wire logic [15:0] req_type,
	input wire logic [13:0] rsp_supplier,
	input wire logic [6:0] rsp_snoop,
	// results
	output logic sel_valid,
	output logic req_hit,
	output logic full_hit
);
	logic [15:0] req_sel;
	logic any_rsp;
	logic [13:0] sup_sel;
	logic [6:0] snp_sel;
	logic rsp_valid;

	// field split; reserved bits already stored as zero
	assign req_sel = filter[OFRF_REQ_MSB:OFRF_REQ_LSB];
	assign any_rsp = filter[OFRF_ANY_RSP_BIT];
	assign sup_sel = filter[OFRF_SUP_MSB:OFRF_SUP_LSB];
	assign snp_sel = filter[OFRF_SNP_MSB:OFRF_SNP_LSB];
	// validity of both halves of the selection
	assign rsp_valid = any_rsp | ((|sup_sel) & (|snp_sel));
	assign sel_valid = (|req_sel) & rsp_valid;
	// several request bits at once are an or of classes
	assign req_hit = |(req_sel & req_type);
	// any-response ignores supplier and snoop detail
	assign full_hit = sel_valid & req_hit & (any_rsp
		| ((|(sup_sel & rsp_supplier)) & (|(snp_sel & rsp_snoop))));
endmodule

// file: ofrf_pkg.sv
// package for the offcore response filter: register map, fields and codes
package ofrf_pkg;
	// ----------------------------------------------------------------
	// register access
	// ----------------------------------------------------------------
	localparam logic [11:0] OFRF_FILTER_ZERO_ADDR = 12'h01a6;
	localparam logic [11:0] OFRF_FILTER_ONE_ADDR = 12'h01a7;
	localparam logic [63:0] OFRF_FILTER_RESET = 64'h0000_0000_0000_0000;
	// writable bits: request 15:0, any 16, second_level_cache_hit_sel 18, snoop 31,33,34,36,37
	localparam logic [63:0] OFRF_FILTER_ONE_MASK = 64'h0000_0036_8005_ffff;
	// filter zero adds the latency measure enable at bit 38
	localparam logic [63:0] OFRF_FILTER_ZERO_MASK = 64'h0000_0076_8005_ffff;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int OFRF_REQ_LSB = 0;
	localparam int OFRF_REQ_MSB = 15;
	localparam int OFRF_ANY_RSP_BIT = 16;
	localparam int OFRF_SUP_LSB = 17;
	localparam int OFRF_SUP_MSB = 30;
	localparam int OFRF_SNP_LSB = 31;
	localparam int OFRF_SNP_MSB = 37;
	localparam int OFRF_LAT_EN_BIT = 38;
	// ----------------------------------------------------------------
	// event select codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OFRF_EVENT_CODE = 8'hb7;
	localparam logic [7:0] OFRF_UMASK_ZERO = 8'h01;
	localparam logic [7:0] OFRF_UMASK_ONE = 8'h02;
	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	localparam int OFRF_CNT_W = 40;
	localparam int OFRF_OUTST_W = 6;
	localparam logic [OFRF_CNT_W-1:0] OFRF_CNT_RESET = 40'h00_0000_0000;
	// counter state enum, one-hot
	typedef enum logic [1:0]
	{
		OFRF_MODE_COUNT = 2'b01,
		OFRF_MODE_LATENCY = 2'b10
	} ofrf_mode_t;
endpackage

// file: ofrf_top.sv
// offcore response filter: two filter registers and two counters
// Operation
// - event 0B7H, umask 01H selects filter zero, 02H filter one
// - request bits 15:0, supplier 30:17, snoop 37:31 in each filter
// - only filter zero has bit 38, enabling latency mode on two counters
// - bits 0-2 demand data read, ownership read, instruction fetch
// - bit 3 writeback, bits 4-6 second-level prefetcher reads
// - bit 7 partial read, 8 partial write, 9 uncacheable fetch
// - bits 10-15 lock, stream store, software_prefetch_sel, l1 pf, partial, any
// - bit 16 any response, 18 second_level_cache_hit_sel, 17 and 30:19 reserved
// - snoop bits 31,33,34,36,37 as listed; 32 and 35 reserved
// - request selection valid only with a non-reserved bit of 15:0 set
// - response valid if any bit, or supplier-or and snoop-or both set
// - invalid request or response selection counts nothing, except filter zero with bit 38 set (latency mode)
// - any-response bit makes supplier and snoop bits ignored
// - multiple request and response bits combine into classes
// - latency mode, counter zero event 01B7H accumulates weighted cycles
`timescale 1ns/1ps
module ofrf_top
	import ofrf_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// register access port
	input wire logic REG_WR,
	input wire logic [11:0] REG_ADDR,
	input wire logic [63:0] REG_WDATA,
	output logic [63:0] REG_RDATA,
	// counter event selects
	input wire logic [15:0] CNT0_EVENT_SEL,
	input wire logic [15:0] CNT1_EVENT_SEL,
	input wire logic CNT_CLEAR,
	// request stream from the core outbound interface
	input wire logic REQ_ISSUE,
	input wire logic [15:0] REQ_TYPE,
	input wire logic REQ_RETIRE,
	input wire logic [15:0] RETIRE_TYPE,
	input wire logic [13:0] RSP_SUPPLIER,
	input wire logic [6:0] RSP_SNOOP,
	// counter values
	output logic [OFRF_CNT_W-1:0] CNT0_VALUE,
	output logic [OFRF_CNT_W-1:0] CNT1_VALUE,
	output logic LATENCY_ACTIVE
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;

	// two-stage release, assertion stays asynchronous
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// filter registers
	// ----------------------------------------------------------------
	logic [63:0] filter_zero_r;
	logic [63:0] filter_one_r;

	// reserved bits are masked on write so they read back zero
	always_ff @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			filter_zero_r <= OFRF_FILTER_RESET;
			filter_one_r <= OFRF_FILTER_RESET;
		end
		else if (REG_WR)
		begin
			if (REG_ADDR == OFRF_FILTER_ZERO_ADDR)
				filter_zero_r <= REG_WDATA & OFRF_FILTER_ZERO_MASK;
			if (REG_ADDR == OFRF_FILTER_ONE_ADDR)
				filter_one_r <= REG_WDATA & OFRF_FILTER_ONE_MASK;
		end
	end

	// registered read data; unmapped addresses read zero
	always_ff @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			REG_RDATA <= OFRF_FILTER_RESET;
		else if (REG_ADDR == OFRF_FILTER_ZERO_ADDR)
			REG_RDATA <= filter_zero_r;
		else if (REG_ADDR == OFRF_FILTER_ONE_ADDR)
			REG_RDATA <= filter_one_r;
		else
			REG_RDATA <= OFRF_FILTER_RESET;
	end

	// ----------------------------------------------------------------
	// matching
	// ----------------------------------------------------------------
	logic valid_zero;
	logic valid_one;
	logic req_hit_zero;
	logic req_hit_one;
	logic hit_zero;
	logic hit_one;
	logic retire_hit_zero;
	logic lat_en;

	// issue-time match against both filters; request bits carry the
	// class encoding of the outbound interface, bit n = class n
	ofrf_match u_match_zero
	(
		.filter(filter_zero_r),
		.req_type(REQ_TYPE),
		.rsp_supplier(RSP_SUPPLIER),
		.rsp_snoop(RSP_SNOOP),
		.sel_valid(valid_zero),
		.req_hit(req_hit_zero),
		.full_hit(hit_zero)
	);

	ofrf_match u_match_one
	(
		.filter(filter_one_r),
		.req_type(REQ_TYPE),
		.rsp_supplier(RSP_SUPPLIER),
		.rsp_snoop(RSP_SNOOP),
		.sel_valid(valid_one),
		.req_hit(req_hit_one),
		.full_hit(hit_one)
	);

	// retirements only need the request-type part of filter zero
	ofrf_match u_match_retire
	(
		.filter(filter_zero_r),
		.req_type(RETIRE_TYPE),
		.rsp_supplier(RSP_SUPPLIER),
		.rsp_snoop(RSP_SNOOP),
		.sel_valid(),
		.req_hit(retire_hit_zero),
		.full_hit()
	);

	assign lat_en = filter_zero_r[OFRF_LAT_EN_BIT];

	// ----------------------------------------------------------------
	// event selection
	// ----------------------------------------------------------------
	logic c0_sel_zero;
	logic c0_sel_one;
	logic c1_sel_zero;
	logic c1_sel_one;
	logic c0_inc;
	logic c1_inc;
	ofrf_mode_t mode;

	// event code low byte, unit mask high byte
	assign c0_sel_zero = CNT0_EVENT_SEL == {OFRF_UMASK_ZERO, OFRF_EVENT_CODE};
	assign c0_sel_one = CNT0_EVENT_SEL == {OFRF_UMASK_ONE, OFRF_EVENT_CODE};
	assign c1_sel_zero = CNT1_EVENT_SEL == {OFRF_UMASK_ZERO, OFRF_EVENT_CODE};
	assign c1_sel_one = CNT1_EVENT_SEL == {OFRF_UMASK_ONE, OFRF_EVENT_CODE};
	// latency mode when filter zero enables it and counter 0 picks it
	assign mode = (lat_en && c0_sel_zero) ? OFRF_MODE_LATENCY
		: OFRF_MODE_COUNT;
	// counter 1 in latency mode counts new requests of the chosen type;
	// response bits are cleared by software so only request type matters
	assign c1_inc = REQ_ISSUE && ((c1_sel_zero && (lat_en
		? ((|filter_zero_r[OFRF_REQ_MSB:OFRF_REQ_LSB]) && req_hit_zero)
		: hit_zero)) || (c1_sel_one && hit_one));
	assign c0_inc = REQ_ISSUE && ((c0_sel_zero && hit_zero)
		|| (c0_sel_one && hit_one));

	// ----------------------------------------------------------------
	// outstanding request tracking
	// ----------------------------------------------------------------
	logic [OFRF_OUTST_W-1:0] outst_r;
	logic [OFRF_OUTST_W-1:0] outst_nxt;
	logic issue_trk;
	logic retire_trk;

	// tracks only filter-zero request types; saturates rather than wrap
	assign issue_trk = REQ_ISSUE && req_hit_zero && !(&outst_r);
	assign retire_trk = REQ_RETIRE && retire_hit_zero && (|outst_r);
	always_comb
	begin
		outst_nxt = outst_r;
		if (issue_trk && !retire_trk)
			outst_nxt = outst_r + OFRF_OUTST_W'(1);
		else if (retire_trk && !issue_trk)
			outst_nxt = outst_r - OFRF_OUTST_W'(1);
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			outst_r <= '0;
		else
			outst_r <= outst_nxt;
	end

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	logic [OFRF_CNT_W-1:0] cnt0_nxt;

	// weighted cycles: add outstanding count each clock
	always_comb
	begin
		cnt0_nxt = CNT0_VALUE;
		unique case (mode)
			OFRF_MODE_LATENCY:
				cnt0_nxt = CNT0_VALUE + {{(OFRF_CNT_W-OFRF_OUTST_W){1'b0}},
					outst_r};
			OFRF_MODE_COUNT:
				cnt0_nxt = CNT0_VALUE + {{(OFRF_CNT_W-1){1'b0}}, c0_inc};
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			CNT0_VALUE <= OFRF_CNT_RESET;
		else if (CNT_CLEAR)
			CNT0_VALUE <= OFRF_CNT_RESET;
		else
			CNT0_VALUE <= cnt0_nxt;
	end

	// counter 1 counts matching issues
	always_ff @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			CNT1_VALUE <= OFRF_CNT_RESET;
		else if (CNT_CLEAR)
			CNT1_VALUE <= OFRF_CNT_RESET;
		else if (c1_inc)
			CNT1_VALUE <= CNT1_VALUE + OFRF_CNT_W'(1);
	end

	// mode flag as an output straight from a flop
	always_ff @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			LATENCY_ACTIVE <= 1'b0;
		else
			LATENCY_ACTIVE <= (mode == OFRF_MODE_LATENCY);
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_rsv_zero;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		((filter_zero_r & ~OFRF_FILTER_ZERO_MASK) == 64'h0)
		&& ((filter_one_r & ~OFRF_FILTER_ONE_MASK) == 64'h0);
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved filter bit set");

	property p_one_no_lat;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		REG_WR && REG_ADDR == OFRF_FILTER_ONE_ADDR
		|=> !filter_one_r[OFRF_LAT_EN_BIT];
	endproperty
	a_one_no_lat: assert property (p_one_no_lat)
		else $error("filter one holds latency bit");

	property p_wr_zero;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		REG_WR && REG_ADDR == OFRF_FILTER_ZERO_ADDR
		|=> filter_zero_r == ($past(REG_WDATA) & OFRF_FILTER_ZERO_MASK);
	endproperty
	a_wr_zero: assert property (p_wr_zero)
		else $error("filter zero write lost");

	property p_invalid_no_count;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		!CNT_CLEAR && c0_sel_zero && !lat_en && !valid_zero
		|=> CNT0_VALUE == $past(CNT0_VALUE);
	endproperty
	a_invalid_no_count: assert property (p_invalid_no_count)
		else $error("count with invalid selection");

	property p_any_count;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		!CNT_CLEAR && c0_sel_one && REQ_ISSUE
		&& filter_one_r[OFRF_ANY_RSP_BIT] && (|(filter_one_r[15:0] & REQ_TYPE))
		|=> CNT0_VALUE == $past(CNT0_VALUE) + 1'b1;
	endproperty
	a_any_count: assert property (p_any_count)
		else $error("any-response match not counted");

	property p_weighted;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		!CNT_CLEAR && mode == OFRF_MODE_LATENCY
		|=> CNT0_VALUE == $past(CNT0_VALUE) + $past(outst_r);
	endproperty
	a_weighted: assert property (p_weighted)
		else $error("weighted cycles wrong");

	property p_rdata;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		REG_ADDR != OFRF_FILTER_ZERO_ADDR && REG_ADDR != OFRF_FILTER_ONE_ADDR
		|=> REG_RDATA == 64'h0;
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("unmapped read not zero");

	property p_c1_count;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		!CNT_CLEAR && c1_sel_one && REQ_ISSUE && hit_one
		|=> CNT1_VALUE == $past(CNT1_VALUE) + 1'b1;
	endproperty
	a_c1_count: assert property (p_c1_count)
		else $error("counter one missed match");

	property p_req_valid;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		filter_zero_r[15:0] == 16'h0 |-> !valid_zero;
	endproperty
	a_req_valid: assert property (p_req_valid)
		else $error("empty request selection valid");

	property p_rsp_valid;
		@(posedge SYS_CLK) disable iff (!rst_n_r)
		(|filter_one_r[15:0]) && (|filter_one_r[30:17])
		&& (|filter_one_r[37:31]) |-> valid_one;
	endproperty
	a_rsp_valid: assert property (p_rsp_valid)
		else $error("supplier and snoop selection invalid");

	c_latency: cover property (@(posedge SYS_CLK) disable iff (!rst_n_r)
		LATENCY_ACTIVE && outst_r > 6'h02);
	c_count_zero: cover property (@(posedge SYS_CLK) disable iff (!rst_n_r)
		c0_inc);
	c_count_one: cover property (@(posedge SYS_CLK) disable iff (!rst_n_r)
		c1_inc && c1_sel_one);
endmodule

// file: ofrf_top_bench.sv
// self-checking bench for the offcore response filter
`timescale 1ns/1ps
`define CHECK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("Error at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module ofrf_top_bench
	import ofrf_pkg::*;
;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk, rst_n, reg_wr, cnt_clear, issue, retire, lat;
	logic [11:0] reg_addr;
	logic [63:0] reg_wdata, reg_rdata;
	logic [15:0] sel0, sel1, req_type, retire_type;
	logic [13:0] sup;
	logic [6:0] snp;
	logic [OFRF_CNT_W-1:0] cnt0, cnt1, mark;
	int errors, n_tests;

	ofrf_top dut_u (.SYS_CLK(clk), .RST_N(rst_n), .REG_WR(reg_wr),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.CNT0_EVENT_SEL(sel0), .CNT1_EVENT_SEL(sel1), .CNT_CLEAR(cnt_clear),
		.REQ_ISSUE(issue), .REQ_TYPE(req_type), .REQ_RETIRE(retire),
		.RETIRE_TYPE(retire_type), .RSP_SUPPLIER(sup), .RSP_SNOOP(snp),
		.CNT0_VALUE(cnt0), .CNT1_VALUE(cnt1), .LATENCY_ACTIVE(lat));

	ofrf_core_model model_u (.clk(clk), .req_issue(issue),
		.req_type(req_type), .rsp_supplier(sup), .rsp_snoop(snp),
		.req_retire(retire), .retire_type(retire_type));

	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [63:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data is registered, so look one edge after the address
	task automatic rd(input logic [11:0] a, input logic [63:0] e);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		@(negedge clk);
		`CHECK(reg_rdata, e);
	endtask

	task automatic clr;
		@(posedge clk);
		cnt_clear <= 1'b1;
		@(posedge clk);
		cnt_clear <= 1'b0;
	endtask

	task automatic cnt(input logic [39:0] e0, input logic [39:0] e1);
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHECK(cnt0, e0);
		`CHECK(cnt1, e1);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog well beyond the expected few hundred cycles
	initial
	begin
		repeat (4000) @(posedge clk);
		errors++;
		stop_test;
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		cnt_clear = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 64'h0000_0000_0000_0000;
		sel0 = 16'h0000;
		sel1 = 16'h0000;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		rd(OFRF_FILTER_ZERO_ADDR, 64'h0000_0000_0000_0000);
		rd(OFRF_FILTER_ONE_ADDR, 64'h0000_0000_0000_0000);
		wr(OFRF_FILTER_ZERO_ADDR, '1);
		wr(OFRF_FILTER_ONE_ADDR, '1);
		wr(12'h01a8, '1);
		rd(OFRF_FILTER_ZERO_ADDR, 64'h0000_0076_8005_ffff);
		rd(OFRF_FILTER_ONE_ADDR, 64'h0000_0036_8005_ffff);
		rd(12'h01a8, 64'h0000_0000_0000_0000);
		$display("test registers done");
		// each request bit alone: zero via any, one via second_level_cache_hit_sel and snoop
		@(posedge clk);
		sel0 <= 16'h01b7;
		sel1 <= 16'h02b7;
		for (int i = 0; i < 16; i++)
		begin
			wr(OFRF_FILTER_ZERO_ADDR, 64'h1_0000 | (64'h1 << i));
			wr(OFRF_FILTER_ONE_ADDR, 64'h8004_0000 | (64'h1 << i));
			clr;
			model_u.issue(16'h1 << i, 14'h0002, 7'h01);
			if (i < 15)
				model_u.issue(16'h1 << (i + 1), 14'h0002, 7'h01);
			cnt(1, 1);
		end
		$display("test request bits done");
		// missing response or request selection never counts
		wr(OFRF_FILTER_ZERO_ADDR, 64'h0000_0000_0000_0009);
		wr(OFRF_FILTER_ONE_ADDR, 64'h0000_0000_0004_0000);
		clr;
		model_u.issue(16'h0001, 14'h0002, 7'h01);
		model_u.issue(16'h0008, 14'h0002, 7'h01);
		cnt(0, 0);
		// supplier without snoop stays invalid; two request classes add
		wr(OFRF_FILTER_ZERO_ADDR, 64'h0000_0000_0001_0009);
		wr(OFRF_FILTER_ONE_ADDR, 64'h0000_0000_0004_0001);
		clr;
		model_u.issue(16'h0001, 14'h0002, 7'h01);
		model_u.issue(16'h0008, 14'h0002, 7'h01);
		cnt(2, 0);
		// any bit ignores supplier; filter one needs the second_level_cache_hit_sel
		wr(OFRF_FILTER_ZERO_ADDR, 64'h0000_0000_8005_0001);
		wr(OFRF_FILTER_ONE_ADDR, 64'h0000_0000_8004_0001);
		clr;
		model_u.issue(16'h0001, 14'h0000, 7'h00);
		cnt(1, 0);
		// wrong event code or unit mask counts nothing
		@(posedge clk);
		sel0 <= 16'h01b6;
		sel1 <= 16'h03b7;
		clr;
		model_u.issue(16'h0001, 14'h0002, 7'h01);
		cnt(0, 0);
		// counter zero on filter one with any bit, counter one on zero
		@(posedge clk);
		sel0 <= 16'h02b7;
		sel1 <= 16'h01b7;
		wr(OFRF_FILTER_ONE_ADDR, 64'h0000_0000_0001_0002);
		clr;
		model_u.issue(16'h0002, 14'h0000, 7'h00);
		cnt(1, 0);
		$display("test validity done");
		// latency: bit 38 with request bit 0, response bits cleared
		@(posedge clk);
		sel0 <= 16'h01b7;
		sel1 <= 16'h01b7;
		wr(OFRF_FILTER_ZERO_ADDR, 64'h0000_0040_0000_0001);
		// earlier tests left requests in flight; the core finishes them
		// so the tracker starts empty (it saturates at zero)
		repeat (32) model_u.retire(16'h0001);
		clr;
		model_u.issue(16'h0001, 14'h0000, 7'h00);
		model_u.issue(16'h0001, 14'h0000, 7'h00);
		repeat (4) @(posedge clk);
		@(negedge clk);
		mark = cnt0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		`CHECK(cnt0 - mark, 40'h0010);
		`CHECK(cnt1, 40'h0002);
		`CHECK(lat, 1'b1);
		model_u.retire(16'h0001);
		model_u.retire(16'h0001);
		repeat (4) @(posedge clk);
		@(negedge clk);
		mark = cnt0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		`CHECK(cnt0, mark);
		$display("test latency done");
		stop_test;
	end
endmodule
